// ===== hdl/bbd_decoder.sv
// Branch and bit-operation decoder with program counter and return stack
//
// Overview of operation
// RQ1 - Conditional branch loads the target only when its test holds.
// RQ2 - Always, never, Z, V and N tests selected by the condition field.
// RQ3 - Unsigned tests use C or Z, and C alone.
// RQ4 - Signed tests use N xor V, and Z or (N xor V) for greater.
// RQ5 - Less-or-equal taken exactly when Z or (N xor V) is one.
// RQ6 - Absolute jump goes to its target without looking at flags.
// RQ7 - Both calls save the return point and go to the subroutine; on a full stack the code jumps without saving and sets the overflow bit.
// RQ8 - Return restores the saved return point into the program counter.
// RQ9 - Set, clear, invert, test take bit number as immediate or index register.
// RQ10 - Carry-with-bit operations take the bit number only as immediate.
// RQ11 - Carry-with-inverted-bit operations take the bit number only as immediate.
// RQ12 - Indirect forms use two words; second word has low nibble zero.
// RQ13 - Direct forms use one word; operation in the high byte.
// RQ14 - Only the low three bits of the index register pick the bit.
// RQ15 - A false branch advances past the branch to the next instruction.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "bbd_regs.svh"
module bbd_decoder #(
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input  wire logic                   mclk,
    input  wire logic                   rst,
    // Register port
    input  wire logic [7:0]             reg_addr,
    input  wire logic [31:0]            reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [31:0]            reg_rdata,
    // Instruction stream and CPU state
    input  wire logic                   instr_valid,
    input  wire logic [15:0]            instr_word,
    input  bbd_pkg::bbd_flags_t         ccr,
    input  bbd_pkg::bbd_gr_file_t       gr_file,
    // Flow results
    output logic      [15:0]            pc,
    output logic                        redirect,
    output logic                        branch_taken,
    // Bit-operation results
    output logic                        bit_valid,
    output bbd_pkg::bbd_bitdec_t        bit_dec,
    output logic                        illegal
);

    // Depth needs one bit more than an index, to tell full from empty
    localparam int IDX_W = $clog2(STACK_DEPTH);
    localparam int SP_W  = $clog2(STACK_DEPTH + 1);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Displacement counts from the word after the branch
    function automatic logic [15:0] rel_target(input logic [15:0] base,
                                               input logic [7:0]  disp);
        rel_target = base + {{8{disp[7]}}, disp};
    endfunction : rel_target

    function automatic logic op_ok(input logic [3:0] op, input logic from_reg);
        op_ok = (op <= `BBD_OP_LAST_BITOP) &&
                (!from_reg || op <= `BBD_OP_LAST_IDXOP);              // RQ9 RQ10 RQ11
    endfunction : op_ok

    typedef enum logic [1:0] {
        st_first  = 2'b00,
        st_second = 2'b01
    } bbd_state_t;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bbd_state_t            state;
    bbd_state_t            next_state;
    logic [15:0]           held;
    logic [15:0]           next_held;
    logic [15:0]           next_pc;
    logic                  next_redirect;
    logic                  next_branch_taken;
    logic                  next_bit_valid;
    bbd_pkg::bbd_bitdec_t  next_bit_dec;
    logic                  next_illegal;
    logic [15:0]           ret_stack [STACK_DEPTH];
    logic [SP_W-1:0]       depth;
    logic [SP_W-1:0]       next_depth;
    logic                  push_en;
    logic [15:0]           push_val;
    logic                  ovf_evt;
    logic                  unf_evt;
    logic                  ctrl_en;
    logic                  next_ctrl_en;
    logic [2:0]            sticky;
    logic [2:0]            next_sticky;
    logic [31:0]           next_rdata;
    logic                  pc_load;
    logic                  cond_true;
    logic [15:0]           seq_pc;
    logic                  stack_full;
    logic                  from_idx;
    logic                  tail_ok;

    bbd_cond_eval u_cond (
        .cond  (bbd_pkg::bbd_cond_t'(instr_word[11:8])),
        .flags (ccr),
        .taken (cond_true)
    );

    assign seq_pc     = pc + `BBD_PC_STEP;
    assign stack_full = (depth == SP_W'(STACK_DEPTH));
    assign pc_load    = reg_wr && (reg_addr == `BBD_REG_PC);

    // ------------------------------------------------------------
    // Decode and flow
    // ------------------------------------------------------------
    always_comb begin
        next_state        = state;
        next_held         = held;
        next_pc           = pc;
        next_redirect     = 1'b0;
        next_branch_taken = 1'b0;
        next_bit_valid    = 1'b0;
        next_bit_dec      = bit_dec;
        next_illegal      = 1'b0;
        next_depth        = depth;
        push_en           = 1'b0;
        push_val          = seq_pc;
        ovf_evt           = 1'b0;
        unf_evt           = 1'b0;
        from_idx          = 1'b0;
        tail_ok           = 1'b0;
        if (pc_load) begin
            // A software load restarts the stream and drops any half-read form
            next_pc       = reg_wdata[15:0];
            next_state    = st_first;
            next_redirect = 1'b1;
        end else if (ctrl_en && instr_valid) begin
            case (state)
                st_first: begin
                    next_pc = seq_pc;                                  // RQ15
                    if (instr_word[15:12] == `BBD_FORM_BRANCH) begin
                        if (cond_true) begin
                            next_pc           = rel_target(seq_pc, instr_word[7:0]); // RQ1
                            next_redirect     = 1'b1;
                            next_branch_taken = 1'b1;
                        end
                    end else if (instr_word[15:8] == `BBD_OP_CALL_REL) begin
                        if (stack_full) begin
                            ovf_evt = 1'b1;
                        end else begin
                            push_en    = 1'b1;                         // RQ7
                            next_depth = depth + SP_W'(1);
                        end
                        next_pc           = rel_target(seq_pc, instr_word[7:0]); // RQ7
                        next_redirect     = 1'b1;
                        next_branch_taken = 1'b1;
                    end else if (instr_word[15:8] == `BBD_OP_RET) begin
                        if (depth == '0) begin
                            unf_evt = 1'b1;
                        end else begin
                            next_depth        = depth - SP_W'(1);
                            next_pc           = ret_stack[IDX_W'(depth - SP_W'(1))]; // RQ8
                            next_redirect     = 1'b1;
                            next_branch_taken = 1'b1;
                        end
                    end else if (instr_word[15:8] == `BBD_OP_JUMP_ABS ||
                                 instr_word[15:8] == `BBD_OP_CALL_ABS) begin
                        next_held  = instr_word;
                        next_state = st_second;
                    end else if (instr_word[15:12] == `BBD_FORM_DIR_IMM) begin
                        if (instr_word[7] || !op_ok(instr_word[11:8], 1'b0)) begin
                            next_illegal = 1'b1;
                        end else begin
                            next_bit_valid                 = 1'b1;    // RQ13
                            next_bit_dec.op                = bbd_pkg::bbd_bitop_t'(instr_word[11:8]);
                            next_bit_dec.mode              = bbd_pkg::mode_reg_direct;
                            next_bit_dec.from_reg          = 1'b0;
                            next_bit_dec.bit_no            = instr_word[6:4];
                            next_bit_dec.operand_reg_field = instr_word[3:0];
                            next_bit_dec.abs_addr          = 8'h00;
                        end
                    end else if (instr_word[15:12] == `BBD_FORM_DIR_IDX) begin
                        if (!op_ok(instr_word[11:8], 1'b1)) begin
                            next_illegal = 1'b1;                       // RQ10 RQ11
                        end else begin
                            next_bit_valid                 = 1'b1;    // RQ9 RQ13
                            next_bit_dec.op                = bbd_pkg::bbd_bitop_t'(instr_word[11:8]);
                            next_bit_dec.mode              = bbd_pkg::mode_reg_direct;
                            next_bit_dec.from_reg          = 1'b1;
                            next_bit_dec.bit_no            = gr_file[instr_word[7:4]][2:0]; // RQ14
                            next_bit_dec.operand_reg_field = instr_word[3:0];
                            next_bit_dec.abs_addr          = 8'h00;
                        end
                    end else if (instr_word[15:12] == `BBD_FORM_IND) begin
                        if (instr_word[3:0] != 4'h0 || !op_ok(instr_word[11:8], 1'b0)) begin
                            next_illegal = 1'b1;                       // RQ12
                        end else begin
                            next_held  = instr_word;
                            next_state = st_second;
                        end
                    end else if (instr_word[15:12] == `BBD_FORM_ABS) begin
                        if (!op_ok(instr_word[11:8], 1'b0)) begin
                            next_illegal = 1'b1;
                        end else begin
                            next_held  = instr_word;
                            next_state = st_second;
                        end
                    end else begin
                        next_illegal = 1'b1;
                    end
                end
                st_second: begin
                    next_state = st_first;
                    next_pc    = seq_pc;
                    if (held[15:8] == `BBD_OP_JUMP_ABS) begin
                        next_pc           = instr_word;                // RQ6
                        next_redirect     = 1'b1;
                        next_branch_taken = 1'b1;
                    end else if (held[15:8] == `BBD_OP_CALL_ABS) begin
                        if (stack_full) begin
                            ovf_evt = 1'b1;
                        end else begin
                            push_en    = 1'b1;                         // RQ7
                            next_depth = depth + SP_W'(1);
                        end
                        next_pc           = instr_word;                // RQ7
                        next_redirect     = 1'b1;
                        next_branch_taken = 1'b1;
                    end else begin
                        from_idx = (instr_word[15:12] == `BBD_FORM_TAIL_IDX);
                        tail_ok  = from_idx ||
                                   (instr_word[15:12] == `BBD_FORM_TAIL_IMM && !instr_word[7]);
                        if (!tail_ok || instr_word[11:8] != held[11:8] ||
                            instr_word[3:0] != 4'h0 || !op_ok(held[11:8], from_idx)) begin
                            next_illegal = 1'b1;                       // RQ12 RQ10 RQ11
                        end else begin
                            next_bit_valid        = 1'b1;             // RQ12
                            next_bit_dec.op       = bbd_pkg::bbd_bitop_t'(held[11:8]);
                            next_bit_dec.from_reg = from_idx;         // RQ9
                            if (from_idx) begin
                                next_bit_dec.bit_no = gr_file[instr_word[7:4]][2:0]; // RQ14
                            end else begin
                                next_bit_dec.bit_no = instr_word[6:4];
                            end
                            if (held[15:12] == `BBD_FORM_IND) begin
                                next_bit_dec.mode              = bbd_pkg::mode_reg_indirect;
                                next_bit_dec.operand_reg_field = held[7:4];
                                next_bit_dec.abs_addr          = 8'h00;
                            end else begin
                                next_bit_dec.mode              = bbd_pkg::mode_absolute;
                                next_bit_dec.operand_reg_field = 4'h0;
                                next_bit_dec.abs_addr          = held[7:0];
                            end
                        end
                    end
                end
                default: begin
                    next_state = st_first;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state        <= st_first;
            held         <= 16'h0000;
            pc           <= `BBD_PC_RST;
            redirect     <= 1'b0;
            branch_taken <= 1'b0;
            bit_valid    <= 1'b0;
            bit_dec      <= '0;
            illegal      <= 1'b0;
            depth        <= '0;
        end else begin
            state        <= next_state;
            held         <= next_held;
            pc           <= next_pc;
            redirect     <= next_redirect;
            branch_taken <= next_branch_taken;
            bit_valid    <= next_bit_valid;
            bit_dec      <= next_bit_dec;
            illegal      <= next_illegal;
            depth        <= next_depth;
        end
    end

    // Return addresses need no reset; depth alone says which entries hold data
    always_ff @(posedge mclk) begin
        if (push_en) begin
            ret_stack[IDX_W'(depth)] <= push_val;                      // RQ7
        end
    end

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    always_comb begin
        next_ctrl_en = ctrl_en;
        next_sticky  = sticky;
        next_rdata   = 32'h0000_0000;
        if (reg_wr && reg_addr == `BBD_REG_CTRL) begin
            next_ctrl_en = reg_wdata[`BBD_CTRL_EN_BIT];
        end
        if (reg_wr && reg_addr == `BBD_REG_STAT) begin
            next_sticky = sticky & ~reg_wdata[2:0];
        end
        // A new event wins over a clear in the same cycle
        next_sticky[`BBD_STAT_ILL_BIT] = next_sticky[`BBD_STAT_ILL_BIT] | next_illegal;
        next_sticky[`BBD_STAT_OVF_BIT] = next_sticky[`BBD_STAT_OVF_BIT] | ovf_evt;
        next_sticky[`BBD_STAT_UNF_BIT] = next_sticky[`BBD_STAT_UNF_BIT] | unf_evt;
        if (reg_rd) begin
            if (reg_addr == `BBD_REG_CTRL) begin
                next_rdata[`BBD_CTRL_EN_BIT] = ctrl_en;
            end else if (reg_addr == `BBD_REG_PC) begin
                next_rdata[15:0] = pc;
            end else if (reg_addr == `BBD_REG_STAT) begin
                next_rdata[2:0] = sticky;
                next_rdata[`BBD_STAT_DEPTH_LSB +: 8] = 8'(depth);
            end else if (reg_addr == `BBD_REG_LAST) begin
                next_rdata[$bits(bbd_pkg::bbd_bitdec_t)-1:0] = bit_dec;
            end else begin
                next_rdata = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_en   <= `BBD_CTRL_RST;
            sticky    <= 3'h0;
            reg_rdata <= 32'h0000_0000;
        end else begin
            ctrl_en   <= next_ctrl_en;
            sticky    <= next_sticky;
            reg_rdata <= next_rdata;
        end
    end

endmodule : bbd_decoder

// ===== hdl/bbd_regs.svh
// Register offsets, field positions, reset values and opcode fields of the decoder
`ifndef BBD_REGS_SVH
`define BBD_REGS_SVH

// ------------------------------------------------------------
// Register offsets
// ------------------------------------------------------------
`define BBD_REG_CTRL       8'h00
`define BBD_REG_PC         8'h04
`define BBD_REG_STAT       8'h08
`define BBD_REG_LAST       8'h0c

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define BBD_CTRL_EN_BIT    0
`define BBD_STAT_ILL_BIT   0
`define BBD_STAT_OVF_BIT   1
`define BBD_STAT_UNF_BIT   2
`define BBD_STAT_DEPTH_LSB 8

// ------------------------------------------------------------
// Reset values and program counter step
// ------------------------------------------------------------
`define BBD_CTRL_RST       1'b1
`define BBD_PC_RST         16'h0000
`define BBD_PC_STEP        16'h0002

// ------------------------------------------------------------
// Opcode fields (upper nibble or upper byte of the first or second word)
// ------------------------------------------------------------
`define BBD_FORM_BRANCH    4'h4
`define BBD_FORM_DIR_IMM   4'h6
`define BBD_FORM_DIR_IDX   4'h7
`define BBD_FORM_IND       4'h8
`define BBD_FORM_ABS       4'h9
`define BBD_FORM_TAIL_IMM  4'ha
`define BBD_FORM_TAIL_IDX  4'hb
`define BBD_OP_RET         8'h54
`define BBD_OP_CALL_REL    8'h55
`define BBD_OP_JUMP_ABS    8'h5a
`define BBD_OP_CALL_ABS    8'h5e
`define BBD_OP_LAST_BITOP  4'hd
`define BBD_OP_LAST_IDXOP  4'h3

`endif

// ===== hdl/bbd_pkg.sv
// Types shared by the branch and bit-operation decoder
package bbd_pkg;

    // ------------------------------------------------------------
    // Branch conditions
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        unconditional_jump_rel = 4'h0,
        never_taken            = 4'h1,
        unsigned_above         = 4'h2,
        unsigned_below_equal   = 4'h3,
        carry_clear_cond       = 4'h4,
        carry_set_cond         = 4'h5,
        not_equal_cond         = 4'h6,
        equal_cond             = 4'h7,
        overflow_clear_cond    = 4'h8,
        overflow_set_cond      = 4'h9,
        positive_cond          = 4'ha,
        negative_cond          = 4'hb,
        signed_ge_cond         = 4'hc,
        signed_lt_cond         = 4'hd,
        signed_gt_cond         = 4'he,
        signed_le_cond         = 4'hf
    } bbd_cond_t;

    // ------------------------------------------------------------
    // Bit operations and operand modes
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        bit_set_op       = 4'h0,
        bit_clear_op     = 4'h1,
        bit_invert_op    = 4'h2,
        bit_test_op      = 4'h3,
        carry_and_bit    = 4'h4,
        carry_or_bit     = 4'h5,
        carry_xor_bit    = 4'h6,
        bit_to_carry     = 4'h7,
        carry_to_bit     = 4'h8,
        carry_and_notbit = 4'h9,
        carry_or_notbit  = 4'ha,
        carry_xor_notbit = 4'hb,
        notbit_to_carry  = 4'hc,
        notcarry_to_bit  = 4'hd
    } bbd_bitop_t;

    typedef enum logic [1:0] {
        mode_reg_direct   = 2'b00,
        mode_reg_indirect = 2'b01,
        mode_absolute     = 2'b10
    } bbd_mode_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic n;
        logic z;
        logic v;
        logic c;
    } bbd_flags_t;

    typedef struct packed {
        bbd_bitop_t op;
        bbd_mode_t  mode;
        logic       from_reg;
        logic [2:0] bit_no;
        logic [3:0] operand_reg_field;
        logic [7:0] abs_addr;
    } bbd_bitdec_t;

    typedef logic [15:0][7:0] bbd_gr_file_t;

endpackage : bbd_pkg

// ===== hdl/bbd_cond_eval.sv
// Branch condition evaluation against the condition flags
`timescale 1ns/10ps
module bbd_cond_eval (
    // Selected test
    input  bbd_pkg::bbd_cond_t cond,
    // Condition flags
    input  bbd_pkg::bbd_flags_t flags,
    // Result
    output logic                taken
);

    logic nxv;

    assign nxv = flags.n ^ flags.v;

    always_comb begin
        case (cond)
            bbd_pkg::unconditional_jump_rel: taken = 1'b1;                   // RQ2
            bbd_pkg::never_taken:            taken = 1'b0;                   // RQ2
            bbd_pkg::unsigned_above:         taken = ~(flags.c | flags.z);   // RQ3
            bbd_pkg::unsigned_below_equal:   taken = flags.c | flags.z;      // RQ3
            bbd_pkg::carry_clear_cond:       taken = ~flags.c;               // RQ3
            bbd_pkg::carry_set_cond:         taken = flags.c;                // RQ3
            bbd_pkg::not_equal_cond:         taken = ~flags.z;               // RQ2
            bbd_pkg::equal_cond:             taken = flags.z;                // RQ2
            bbd_pkg::overflow_clear_cond:    taken = ~flags.v;               // RQ2
            bbd_pkg::overflow_set_cond:      taken = flags.v;                // RQ2
            bbd_pkg::positive_cond:          taken = ~flags.n;               // RQ2
            bbd_pkg::negative_cond:          taken = flags.n;                // RQ2
            bbd_pkg::signed_ge_cond:         taken = ~nxv;                   // RQ4
            bbd_pkg::signed_lt_cond:         taken = nxv;                    // RQ4
            bbd_pkg::signed_gt_cond:         taken = ~(flags.z | nxv);       // RQ4
            bbd_pkg::signed_le_cond:         taken = flags.z | nxv;          // RQ5
            default:                         taken = 1'b0;
        endcase
    end

endmodule : bbd_cond_eval

// ===== tb/bbd_decoder_properties.sv
// Port checker of the branch and bit-operation decoder
`timescale 1ns/10ps
module bbd_chk (
    input wire logic mclk, rst, reg_wr, instr_valid, redirect, branch_taken,
    input wire logic bit_valid, illegal,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic [15:0] instr_word, pc,
    input bbd_pkg::bbd_flags_t ccr,
    input bbd_pkg::bbd_gr_file_t gr_file,
    input bbd_pkg::bbd_bitdec_t bit_dec
);
    logic en;
    wire [7:0] op = instr_word[15:8];
    wire go = instr_valid && en && !(reg_wr && reg_addr == 8'h04);
    wire br = go && op[7:4] == 4'h4;
    wire nv = ccr.n ^ ccr.v;
    wire [7:0] t = {ccr.z | nv, nv, ccr.n, ccr.v, ccr.z, ccr.c, ccr.c | ccr.z, 1'b0};
    wire tk = t[instr_word[11:9]] ^ ~instr_word[8];
    wire [15:0] nx = pc + 16'd2;
    wire [15:0] tgt = nx + {{8{instr_word[7]}}, instr_word[7:0]};
    wire [2:0] ix = gr_file[instr_word[7:4]][2:0];
    // Words offered while disabled are dropped, so they must not be judged
    always_ff @(posedge mclk)
        en <= rst ? 1'b1 : (reg_wr && reg_addr == 8'h00) ? reg_wdata[0] : en;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    property p_take; br && tk |=> redirect && branch_taken && pc == $past(tgt); endproperty
    a_take: assert property (p_take) else $error("taken branch wrong");
    property p_skip; br && !tk |=> !redirect && !branch_taken && pc == $past(nx); endproperty
    a_skip: assert property (p_skip) else $error("untaken branch wrong");
    property p_jmp; go && op == 8'h5a ##1 go |=> redirect && pc == $past(instr_word); endproperty
    a_jmp: assert property (p_jmp) else $error("jump wrong");
    property p_call; go && op == 8'h55 |=> branch_taken && pc == $past(tgt); endproperty
    a_call: assert property (p_call) else $error("call wrong");
    property p_ret; go && op == 8'h55 ##1 (go && op == 8'h54) |=> pc == $past(pc, 2) + 16'd2;
    endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_dir; go && op[7:4] == 4'h6 && !instr_word[7] && op[3:0] <= 4'hd |=> bit_valid
        && bit_dec[21:8] == {$past(op[3:0]), 3'b000, $past(instr_word[6:0])}; endproperty
    a_dir: assert property (p_dir) else $error("direct bit form wrong");
    property p_idx; go && op[7:2] == 6'b011100 |=> bit_valid && bit_dec.bit_no == $past(ix);
    endproperty
    a_idx: assert property (p_idx) else $error("index bit wrong");
    property p_ill; go && op[7:4] == 4'h7 && op[3:2] != 2'b00 |=> illegal && !bit_valid;
    endproperty
    a_ill: assert property (p_ill) else $error("index form accepted");
endmodule : bbd_chk

// ===== tb/testbench.sv
// Self-checking testbench of the branch and bit-operation decoder
`timescale 1ns/10ps
module testbench;
    logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, instr_valid = 0;
    logic redirect, branch_taken, bit_valid, illegal;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, r;
    logic [15:0] instr_word = 16'h0, pc, mpc = 16'h0;
    logic [15:0] cw[8] = '{16'h5580, 16'h5400, 16'h5a00, 16'h0346, 16'h5e00, 16'h0120,
        16'h5400, 16'h5400};
    logic [15:0] cp[8] = '{16'h0182, 16'h0202, 16'h0204, 16'h0346, 16'h0348, 16'h0120,
        16'h034a, 16'h034c};
    bbd_pkg::bbd_flags_t ccr = 4'h0;
    bbd_pkg::bbd_gr_file_t gr_file = '0, g;
    bbd_pkg::bbd_bitdec_t bit_dec;
    int seed = 32'ha145, num_errors = 0, total_checks = 0, cyc = 0;
    bbd_decoder i_dut (.*);
    always #5 mclk = ~mclk;
    // The sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            final_report();
        end
    end
    function automatic logic taken(logic [3:0] c, logic [3:0] f);
        logic [7:0] t;
        t = {f[2] | (f[3] ^ f[1]), f[3] ^ f[1], f[3], f[1], f[2], f[0], f[0] | f[2], 1'b0};
        return t[c[3:1]] ^ ~c[0];
    endfunction : taken
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic op(logic [15:0] w);
        instr_valid <= 1'b1;
        instr_word <= w;
        @(posedge mclk);
        instr_valid <= 1'b0;
        #1 chk("pc", 32'(pc), 32'(mpc));
    endtask : op
    task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1;
    endtask : acc
    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        #1;
        for (int i = 0; i < 5; i++) begin
            acc(0, 8'(4 * i), 0);
            chk("reg", reg_rdata, 32'(i == 0));
        end
        for (int i = 0; i < 96; i++) begin
            r = $random(seed);
            ccr <= r[11:8];
            mpc += taken(i[3:0], r[11:8]) ? 16'd2 + {{8{r[7]}}, r[7:0]} : 16'd2;
            op({4'h4, i[3:0], r[7:0]});
        end
        acc(1, 8'h00, 0);
        op(16'h4000);
        acc(1, 8'h00, 1);
        $display("branch test done");
        acc(1, 8'h04, 32'h0200);
        foreach (cw[k]) begin
            mpc = cp[k];
            op(cw[k]);
        end
        acc(0, 8'h08, 0);
        chk("stat", reg_rdata, 32'h4);
        acc(1, 8'h08, 32'h4);
        $display("flow test done");
        for (int o = 0; o < 14; o++) begin
            r = $random(seed);
            g = {4{$random(seed)}};
            gr_file <= g;
            mpc += 2;
            op({4'h6, o[3:0], 1'b0, r[6:0]});
            chk("dir", 32'({bit_valid, bit_dec[21:8]}), 32'({1'b1, o[3:0], 3'b000, r[6:0]}));
            mpc += 2;
            op({4'h7, o[3:0], r[7:0]});
            chk("idx", 32'({illegal, bit_valid}), o < 4 ? 32'h1 : 32'h2);
            if (o < 4) chk("bit", 32'(bit_dec.bit_no), 32'(g[r[7:4]][2:0]));
            mpc += 2;
            op({4'h8, o[3:0], r[11:8], 4'h0});
            chk("first", 32'(bit_valid), 0);
            mpc += 2;
            op({4'ha, o[3:0], 1'b0, r[14:12], 4'h0});
            chk("ind", 32'(bit_dec[21:8]), 32'({o[3:0], 3'b010, r[14:12], r[11:8]}));
            mpc += 2;
            op({4'h9, o[3:0], r[7:0]});
            mpc += 2;
            op({4'hb, o[3:0], r[7:4], 4'h0});
            chk("abs", 32'({illegal, bit_dec[17:0]}), 32'(o < 4 ? {4'h5, g[r[7:4]][2:0], 4'h0,
                r[7:0]} : {4'ha, r[14:8], 8'h00}));
        end
        $display("bit test done");
        final_report();
    end
endmodule : testbench
bind bbd_decoder bbd_chk i_chk (.*);
